//--- design/gptl_regs.sv
// Output level, DAC preset, averaging and temperature limit registers.
// Assumes a register port in the clk_sys domain and finished averages
// delivered by the measurement path as one-cycle valid strobes.
//
// Functional notes
// RULE1: Twenty output bits split over two registers.
// RULE2: Output bit zero drives output port low.
// RULE3: Output bit one drives output port high.
// RULE4: Output level word reads back as written.
// RULE5: Two 12-bit preset words, host read/write.
// RULE6: Presets feed all DAC-mode ports.
// RULE7: Preset writes leave port DAC data untouched.
// RULE8: Bits 1:0 select internal averaging depth.
// RULE9: Bits 3:2 select first remote depth.
// RULE10: Bits 5:4 select second remote depth.
// RULE11: Six 12-bit two's-complement limits, 0.125C.
// RULE12: Internal above high limit sets bit 2.
// RULE13: Internal below low limit sets bit 1.
// RULE14: First remote above high sets bit 2.
// RULE15: First remote below low sets bit 1.
// RULE16: Second remote above high sets bit 2.
// RULE17: Second remote below low sets bit 1.
// RULE18: Limit checks run only for enabled sensors.
// RULE19: Signed compare on each new enabled average.
`include "gptl_map.svh"
module gptl_regs
(
    // Clock and reset
    input  wire logic               clk_sys,
    input  wire logic               reset_n,
    // Register port
    input  wire gptl_pkg::gptl_req_t req,
    output logic [15:0]             rdata,
    output logic                    rvalid,
    // Port side
    input  wire logic [19:0]        output_mode,
    output logic [19:0]             digital_output_port,
    output logic [11:0]             dac_preset_one,
    output logic [11:0]             dac_preset_two,
    // Measurement side
    input  wire gptl_pkg::gptl_temp_t internal_temp,
    input  wire gptl_pkg::gptl_temp_t remote_one_temp,
    input  wire gptl_pkg::gptl_temp_t remote_two_temp,
    output gptl_pkg::gptl_avg_t     internal_average_depth,
    output gptl_pkg::gptl_avg_t     remote_one_average_depth,
    output gptl_pkg::gptl_avg_t     remote_two_average_depth,
    output logic [2:0]              sensor_enable_select,
    output logic [8:0]              temp_flags
);
    logic        rst_meta;
    logic        rst_n;
    logic [19:0] output_level_bits;
    logic [19:0] next_output_level_bits;
    logic [11:0] next_preset_one;
    logic [11:0] next_preset_two;
    logic [5:0]  avg_cfg;
    logic [5:0]  next_avg_cfg;
    logic [11:0] limit_hi [3];
    logic [11:0] limit_lo [3];
    logic [11:0] next_limit_hi [3];
    logic [11:0] next_limit_lo [3];
    logic [2:0]  next_enable;
    logic [8:0]  next_flags;
    logic [15:0] next_rdata;
    logic        next_rvalid;
    gptl_pkg::gptl_temp_t temps [3];

    // Reset leaves through two flops so release is clean in clk_sys.
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    function automatic logic above(input logic [11:0] t,
                                   input logic [11:0] lim);
        above = $signed(t) > $signed(lim); // RULE19
    endfunction

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = req.wr && (a == b);
    endfunction

    assign temps[0] = internal_temp;
    assign temps[1] = remote_one_temp;
    assign temps[2] = remote_two_temp;

    // Only ports in output mode follow the level bits; others stay low.
    assign digital_output_port = output_level_bits & output_mode; // RULE2 RULE3
    assign internal_average_depth   = gptl_pkg::gptl_avg_t'(avg_cfg[1:0]); // RULE8
    assign remote_one_average_depth = gptl_pkg::gptl_avg_t'(avg_cfg[3:2]); // RULE9
    assign remote_two_average_depth = gptl_pkg::gptl_avg_t'(avg_cfg[5:4]); // RULE10

    // The stored word is kept whatever mode each port is in.
    always_comb
    begin
        next_output_level_bits = output_level_bits;
        if (hit(req.idx, `GPTL_IDX_OUT_LOW))
            next_output_level_bits[15:0] = req.wdata; // RULE1
        if (hit(req.idx, `GPTL_IDX_OUT_HIGH))
            next_output_level_bits[19:16] = req.wdata[3:0]; // RULE1
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            output_level_bits <= 20'h0_0000;
        end
        else
        begin
            output_level_bits <= next_output_level_bits;
        end
    end

    // Presets have their own storage; per-port DAC data is elsewhere.
    always_comb
    begin
        next_preset_one = dac_preset_one;
        next_preset_two = dac_preset_two;
        if (hit(req.idx, `GPTL_IDX_PRESET_ONE))
            next_preset_one = req.wdata[11:0]; // RULE5 RULE7
        if (hit(req.idx, `GPTL_IDX_PRESET_TWO))
            next_preset_two = req.wdata[11:0]; // RULE5 RULE7
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dac_preset_one <= 12'h000;
            dac_preset_two <= 12'h000;
        end
        else
        begin
            dac_preset_one <= next_preset_one; // RULE6
            dac_preset_two <= next_preset_two; // RULE6
        end
    end

    // Depth codes leave undecoded; the averaging path maps them.
    always_comb
    begin
        next_avg_cfg = avg_cfg;
        next_enable  = sensor_enable_select;
        if (hit(req.idx, `GPTL_IDX_AVG_CFG))
            next_avg_cfg = req.wdata[5:0]; // RULE8 RULE9 RULE10
        if (hit(req.idx, `GPTL_IDX_ENABLE))
            next_enable = req.wdata[2:0]; // RULE18
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            avg_cfg              <= 6'h00;
            sensor_enable_select <= 3'h0;
        end
        else
        begin
            avg_cfg              <= next_avg_cfg;
            sensor_enable_select <= next_enable;
        end
    end

    // Each limit register keeps only its low twelve bits.
    // Limits reset to the extremes, so no flag sets before setup.
    always_comb
    begin
        next_limit_hi = limit_hi;
        next_limit_lo = limit_lo;
        if (hit(req.idx, `GPTL_IDX_INT_HI))
            next_limit_hi[0] = req.wdata[11:0]; // RULE11
        if (hit(req.idx, `GPTL_IDX_INT_LO))
            next_limit_lo[0] = req.wdata[11:0]; // RULE11
        if (hit(req.idx, `GPTL_IDX_R1_HI))
            next_limit_hi[1] = req.wdata[11:0]; // RULE11
        if (hit(req.idx, `GPTL_IDX_R1_LO))
            next_limit_lo[1] = req.wdata[11:0]; // RULE11
        if (hit(req.idx, `GPTL_IDX_R2_HI))
            next_limit_hi[2] = req.wdata[11:0]; // RULE11
        if (hit(req.idx, `GPTL_IDX_R2_LO))
            next_limit_lo[2] = req.wdata[11:0]; // RULE11
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int s = 0; s < 3; s++)
            begin
                limit_hi[s] <= `GPTL_RESET_HI_LIMIT;
                limit_lo[s] <= `GPTL_RESET_LO_LIMIT;
            end
        end
        else
        begin
            limit_hi <= next_limit_hi;
            limit_lo <= next_limit_lo;
        end
    end

    // A value equal to a limit sets nothing; both compares are strict.
    function automatic logic [2:0] crossing(input gptl_pkg::gptl_temp_t t,
                                            input logic              enabled,
                                            input logic [11:0]       hi,
                                            input logic [11:0]       lo);
        crossing = 3'b000;
        if (t.valid && enabled) // RULE18
        begin
            crossing[`GPTL_HIGH_FLAG_BIT] = above(t.value, hi);
            crossing[`GPTL_LOW_FLAG_BIT]  = above(lo, t.value);
        end
    endfunction

    // Writing ones clears flags; a same-cycle event below still wins.
    always_comb
    begin
        next_flags = temp_flags;
        if (hit(req.idx, `GPTL_IDX_FLAGS))
            next_flags = temp_flags & ~req.wdata[8:0];
        next_flags[2:0] = next_flags[2:0] // RULE12 RULE13
                        | crossing(temps[0], sensor_enable_select[0],
                                   limit_hi[0], limit_lo[0]);
        next_flags[5:3] = next_flags[5:3] // RULE14 RULE15
                        | crossing(temps[1], sensor_enable_select[1],
                                   limit_hi[1], limit_lo[1]);
        next_flags[8:6] = next_flags[8:6] // RULE16 RULE17
                        | crossing(temps[2], sensor_enable_select[2],
                                   limit_hi[2], limit_lo[2]);
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            temp_flags <= 9'h000;
        end
        else
        begin
            temp_flags <= next_flags;
        end
    end

    // Narrow registers read back with zeros above their top bit.
    function automatic logic [15:0] widen(input logic [11:0] v);
        widen = {4'h0, v};
    endfunction

    // Read data stands until the next read; unmapped indices read zero.
    always_comb
    begin
        next_rdata  = rdata;
        next_rvalid = req.rd;
        if (req.rd)
        begin
            if (req.idx == `GPTL_IDX_OUT_LOW)
                next_rdata = output_level_bits[15:0]; // RULE4
            else if (req.idx == `GPTL_IDX_OUT_HIGH)
                next_rdata = {12'h000, output_level_bits[19:16]}; // RULE4
            else if (req.idx == `GPTL_IDX_PRESET_ONE)
                next_rdata = widen(dac_preset_one);
            else if (req.idx == `GPTL_IDX_PRESET_TWO)
                next_rdata = widen(dac_preset_two);
            else if (req.idx == `GPTL_IDX_AVG_CFG)
                next_rdata = {10'h000, avg_cfg};
            else if (req.idx == `GPTL_IDX_INT_HI)
                next_rdata = widen(limit_hi[0]);
            else if (req.idx == `GPTL_IDX_INT_LO)
                next_rdata = widen(limit_lo[0]);
            else if (req.idx == `GPTL_IDX_R1_HI)
                next_rdata = widen(limit_hi[1]);
            else if (req.idx == `GPTL_IDX_R1_LO)
                next_rdata = widen(limit_lo[1]);
            else if (req.idx == `GPTL_IDX_R2_HI)
                next_rdata = widen(limit_hi[2]);
            else if (req.idx == `GPTL_IDX_R2_LO)
                next_rdata = widen(limit_lo[2]);
            else if (req.idx == `GPTL_IDX_FLAGS)
                next_rdata = {7'h00, temp_flags};
            else if (req.idx == `GPTL_IDX_ENABLE)
                next_rdata = {13'h0000, sensor_enable_select};
            else
                next_rdata = 16'h0000;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata  <= `GPTL_RESET_VALUE;
            rvalid <= 1'b0;
        end
        else
        begin
            rdata  <= next_rdata;
            rvalid <= next_rvalid;
        end
    end
endmodule

//--- design/gptl_map.svh
// Register indices, field positions and reset values of the limit bank.
// Assumes the includer works on 16-bit register words.
`ifndef GPTL_MAP_SVH
`define GPTL_MAP_SVH
`define GPTL_IDX_OUT_LOW     8'h00
`define GPTL_IDX_OUT_HIGH    8'h01
`define GPTL_IDX_PRESET_ONE  8'h02
`define GPTL_IDX_PRESET_TWO  8'h03
`define GPTL_IDX_AVG_CFG     8'h04
`define GPTL_IDX_INT_HI      8'h05
`define GPTL_IDX_INT_LO      8'h06
`define GPTL_IDX_R1_HI       8'h07
`define GPTL_IDX_R1_LO       8'h08
`define GPTL_IDX_R2_HI       8'h09
`define GPTL_IDX_R2_LO       8'h0a
`define GPTL_IDX_FLAGS       8'h0b
`define GPTL_IDX_ENABLE      8'h0c
`define GPTL_HIGH_FLAG_BIT   2
`define GPTL_LOW_FLAG_BIT    1
`define GPTL_RESET_VALUE     16'h0000
`define GPTL_RESET_HI_LIMIT  12'h7ff
`define GPTL_RESET_LO_LIMIT  12'h800
`endif

//--- design/gptl_pkg.sv
// Types shared by the limit bank.
// Assumes the map header supplies every number.
package gptl_pkg;
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  idx;
        logic [15:0] wdata;
    } gptl_req_t;
    typedef struct packed {
        logic        valid;
        logic [11:0] value;
    } gptl_temp_t;
    typedef enum logic [1:0] {
        GPTL_AVG_4,
        GPTL_AVG_8,
        GPTL_AVG_16,
        GPTL_AVG_32
    } gptl_avg_t;
endpackage

//--- verif/gptl_monitor.sv
// Checker for the limit bank's register port and outputs.
// Assumes it is bound into gptl_regs, one clk_sys domain.
module gptl_monitor
(
    // Clock and reset
    input wire logic                 clk_sys,
    input wire logic                 reset_n,
    // Observed ports
    input wire gptl_pkg::gptl_req_t  req,
    input wire logic                 rvalid,
    input wire logic [19:0]          output_mode,
    input wire logic [19:0]          digital_output_port,
    input wire logic [11:0]          dac_preset_one,
    input wire gptl_pkg::gptl_avg_t  internal_average_depth,
    input wire gptl_pkg::gptl_temp_t internal_temp,
    input wire gptl_pkg::gptl_temp_t remote_one_temp,
    input wire logic [2:0]           sensor_enable_select,
    input wire logic [8:0]           temp_flags
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);
    AST_READ_ANSWER: assert property (req.rd |=> rvalid)
        else $error("read not answered");
    AST_READ_ONCE: assert property (!req.rd |=> !rvalid)
        else $error("stray read answer");
    AST_IDLE_LOW: assert property (
        (digital_output_port & ~output_mode) == 20'h0_0000)
        else $error("unconfigured port driven");
    AST_OUT_WRITE: assert property (
        req.wr && req.idx == 8'h00 |=>
        digital_output_port[15:0] == ($past(req.wdata) & output_mode[15:0]))
        else $error("output level wrong");
    AST_PRESET: assert property (req.wr && req.idx == 8'h02 |=>
        dac_preset_one == $past(req.wdata[11:0])) else $error("preset wrong");
    AST_DEPTH: assert property (req.wr && req.idx == 8'h04 |=>
        internal_average_depth == $past(req.wdata[1:0])) else $error("depth");
    AST_HIGH_CAUSE: assert property ($rose(temp_flags[2]) |->
        $past(internal_temp.valid && sensor_enable_select[0]))
        else $error("high flag without cause");
    AST_LOW_CAUSE: assert property ($rose(temp_flags[4]) |->
        $past(remote_one_temp.valid && sensor_enable_select[1]))
        else $error("low flag without cause");
    AST_STICKY: assert property (
        temp_flags[2] && !(req.wr && req.idx == 8'h0b) |=> temp_flags[2])
        else $error("flag lost");
    cover property (req.rd && req.idx == 8'h05);
    cover property ($rose(temp_flags[2]));
    cover property (req.wr && req.idx == 8'h04);
endmodule
bind gptl_regs gptl_monitor mon (.clk_sys, .reset_n, .req, .rvalid,
    .output_mode, .digital_output_port, .dac_preset_one,
    .internal_average_depth, .internal_temp, .remote_one_temp,
    .sensor_enable_select, .temp_flags);

//--- verif/gptl_host.sv
// Host model issuing register reads and writes on the request port.
// Assumes each task is entered just after a rising clk_sys edge.
module gptl_host
(
    // Clock
    input  wire logic           clk_sys,
    // Register port
    output gptl_pkg::gptl_req_t req,
    input  wire logic [15:0]    rdata,
    input  wire logic           rvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    initial req = '0;
    // A gap cycle follows each strobe, so no strobe is set twice at once.
    task automatic wr(input logic [7:0] i, input logic [15:0] d);
        req <= '{1'b1, 1'b0, i, d};
        @(posedge clk_sys) req <= '0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] i, output logic [15:0] d);
        req <= '{1'b0, 1'b1, i, 16'h0000};
        @(posedge clk_sys) req <= '0;
        @(posedge clk_sys);
        d = rvalid ? rdata : 16'hxxxx;
    endtask
endmodule

//--- verif/gptl_regs_tb.sv
// Self-checking bench for the limit bank.
// Assumes the host model and the checker are compiled before it.
module gptl_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                 clk_sys;
    logic                 reset_n;
    gptl_pkg::gptl_req_t  req;
    logic [15:0]          rdata;
    logic                 rvalid;
    logic [19:0]          output_mode;
    logic [19:0]          digital_output_port;
    logic [11:0]          preset [2];
    gptl_pkg::gptl_avg_t  depth [3];
    logic [2:0]           sensor_enable_select;
    logic [8:0]           temp_flags;
    gptl_pkg::gptl_temp_t tmp [3];
    logic [31:0]          seed;
    logic [15:0]          w [11];
    logic [15:0]          r;
    int                   n_fail = 0;
    int                   total_checks = 0;
    int                   cyc = 0;
    gptl_host host (.clk_sys, .req, .rdata, .rvalid);
    gptl_regs dut (.clk_sys, .reset_n, .req, .rdata, .rvalid, .output_mode,
        .digital_output_port, .dac_preset_one(preset[0]),
        .dac_preset_two(preset[1]), .internal_temp(tmp[0]),
        .remote_one_temp(tmp[1]), .remote_two_temp(tmp[2]),
        .internal_average_depth(depth[0]), .remote_one_average_depth(depth[1]),
        .remote_two_average_depth(depth[2]), .sensor_enable_select,
        .temp_flags);
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [15:0] mask(input int i);
        return i == 0 ? 16'hffff : i == 1 ? 16'h000f : i == 4 ? 16'h003f :
            16'h0fff;
    endfunction
    function automatic logic [15:0] rst(input int i);
        return i > 10 || i < 5 ? 16'h0000 : i % 2 ? 16'h07ff : 16'h0800;
    endfunction
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Limits are strict, so a value equal to a limit must leave flags alone.
    task automatic pulse(input logic [11:0] v, input logic [8:0] exp);
        tmp <= '{3{'{1'b1, v}}};
        @(posedge clk_sys) tmp <= '{3{'{1'b0, 12'h000}}};
        repeat (2) @(posedge clk_sys);
        check(temp_flags, exp);
    endtask
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
        if (++cyc == 4000)
        begin
            n_fail++;
            close_out();
        end
    initial
    begin
        reset_n = 1'b0;
        output_mode = 20'h0_0000;
        tmp = '{3{'{1'b0, 12'h000}}};
        seed = 32'h0001_605b;
        repeat (12) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        host.wr(8'h0d, 16'hffff);
        for (int i = 0; i < 14; i++)
        begin
            host.rd(8'(i), r);
            check(r, rst(i));
        end
        for (int n = 0; n < 44; n++)
        begin
            seed = nxt(seed);
            w[n % 11] = seed[15:0] & mask(n % 11);
            output_mode <= seed[31:12];
            host.wr(8'(n % 11), seed[15:0]);
            host.rd(8'(n % 11), r);
            check(r & mask(n % 11), w[n % 11]);
        end
        check(digital_output_port, {w[1][3:0], w[0]} & output_mode);
        check({preset[1], preset[0]}, {w[3][11:0], w[2][11:0]});
        for (int k = 0; k < 4; k++)
        begin
            host.wr(8'h04, 16'(k * 21));
            check({depth[2], depth[1], depth[0]}, 20'(k * 21));
        end
        for (int i = 5; i < 11; i++)
            host.wr(8'(i), i % 2 ? 16'h0010 : 16'h0ff0);
        host.wr(8'h0c, 16'h0003);
        host.wr(8'h0b, 16'h01ff);
        pulse(12'h010, 9'h000);
        pulse(12'hff0, 9'h000);
        pulse(12'hfef, 9'h012);
        pulse(12'h011, 9'h036);
        host.wr(8'h0c, 16'h0007);
        check(sensor_enable_select, 3'h7);
        pulse(12'h011, 9'h136);
        pulse(12'hfef, 9'h1b6);
        // A clear in the same cycle as a new event loses to the event.
        fork
            host.wr(8'h0b, 16'h01ff);
            pulse(12'h011, 9'h124);
        join
        host.wr(8'h0b, 16'h01ff);
        check(temp_flags, 9'h000);
        close_out();
    end
endmodule
